//--- hdl/pdm_map.svh
`ifndef PDM_MAP_SVH
`define PDM_MAP_SVH

// register byte offsets
`define PDM_CPU_CTRL_OFFSET 8'h00
`define PDM_PLL_OFFSET 8'h04
`define PDM_IRQ_EN_OFFSET 8'h08
`define PDM_STAT_OFFSET 8'h0c

// field positions
`define PDM_SEL_MSB 15
`define PDM_SEL_LSB 10
`define PDM_GLOBAL_IRQ_BIT 0
`define PDM_NMI_EN_BIT 1
`define PDM_ENGAGE_BIT 0

// reset values
`define PDM_SEL_RESET 6'h00
`define PDM_GLOBAL_IRQ_RESET 1'b0
`define PDM_ENGAGE_RESET 1'b0
`define PDM_IRQ_EN_RESET 16'h0000

// power-down select codes
`define PDM_CODE_NONE 6'h00
`define PDM_CODE_LIGHT_EN 6'h09
`define PDM_CODE_LIGHT_ANY 6'h11
`define PDM_CODE_PLL_OUT 6'h1a
`define PDM_CODE_PLL_IN 6'h1c

// cycles from the select write to the mode taking effect
`define PDM_ENTRY_CYCLES 4'd9

`endif

//--- hdl/pdm_pkg.sv
`include "pdm_map.svh"
package pdm_pkg;

    typedef enum logic [2:0] {
        MODE_NONE,
        MODE_LIGHT_EN,
        MODE_LIGHT_ANY,
        MODE_PLL_OUT,
        MODE_PLL_IN
    } pdm_mode_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_LIGHT,
        ST_DEEP_OUT,
        ST_DEEP_IN
    } pdm_state_t;

    // reserved codes, including any with the top field bit set, fall to none
    function automatic pdm_mode_t pdm_decode(input logic [5:0] code);
        case (code)
            `PDM_CODE_LIGHT_EN: pdm_decode = MODE_LIGHT_EN;
            `PDM_CODE_LIGHT_ANY: pdm_decode = MODE_LIGHT_ANY;
            `PDM_CODE_PLL_OUT: pdm_decode = MODE_PLL_OUT;
            `PDM_CODE_PLL_IN: pdm_decode = MODE_PLL_IN;
            default: pdm_decode = MODE_NONE;
        endcase
    endfunction : pdm_decode

    typedef struct packed {
        logic ready;
        logic rd_pend;
        logic wr_pend;
        logic [7:0] addr;
        logic [31:0] rdata;
    } pdm_ahb_state_t;

    typedef struct packed {
        logic [3:0] cnt;
        logic pending;
        logic fire;
        pdm_mode_t mode;
    } pdm_timer_state_t;

    typedef struct packed {
        pdm_state_t state;
        pdm_mode_t mode;
        logic [5:0] power_down_select;
        logic global_irq_enable;
        logic pll_engage;
        logic [15:0] irq_enable;
        logic cpu_clock_enable;
        logic dma_clock_enable;
        logic pll_output_enable;
        logic pll_input_enable;
        logic ext_clk_enable;
        logic osc_out_enable;
        logic io_freeze;
        logic isr_take;
        logic resume_at_entry;
        logic deep_ignored;
    } pdm_top_state_t;

endpackage : pdm_pkg

//--- hdl/pdm_bus_if.sv
`timescale 1ns/1ps
interface pdm_bus_if;
    logic wr_en;
    logic [7:0] addr;
    logic [31:0] wr_data;
    logic [31:0] rd_data;

    modport slave (
        output wr_en,
        output addr,
        output wr_data,
        input rd_data
    );
    modport regs (
        input wr_en,
        input addr,
        input wr_data,
        output rd_data
    );
endinterface : pdm_bus_if

//--- hdl/pdm_ahb_slave.sv
`timescale 1ns/1ps
module pdm_ahb_slave (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    pdm_bus_if.slave bus
);
    pdm_pkg::pdm_ahb_state_t s;
    pdm_pkg::pdm_ahb_state_t next_s;
    logic take;

    // only whole-word transfers are used, so the size is not decoded
    assign take = hsel & htrans[1] & hready & (hsize == hsize);

    assign bus.wr_en = s.wr_pend;
    assign bus.addr = s.addr;
    assign bus.wr_data = hwdata;

    always_comb begin
        next_s = s;
        next_s.wr_pend = 1'b0;
        if (s.rd_pend) begin
            // one wait state so read data comes from a flop
            next_s.rdata = bus.rd_data;
            next_s.rd_pend = 1'b0;
            next_s.ready = 1'b1;
        end
        if (take) begin
            next_s.addr = {haddr[7:2], 2'b00};
            next_s.wr_pend = hwrite;
            next_s.rd_pend = ~hwrite;
            next_s.ready = hwrite;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '{ready: 1'b1, rd_pend: 1'b0, wr_pend: 1'b0, addr: 8'h00, rdata: 32'h0000_0000};
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.ready;
    assign hrdata = s.rdata;
    assign hresp = 1'b0;
endmodule : pdm_ahb_slave

//--- hdl/pdm_entry_timer.sv
`timescale 1ns/1ps
`include "pdm_map.svh"
module pdm_entry_timer (
    input wire logic clock,
    input wire logic rst,
    input wire logic start,
    input wire logic [5:0] code,
    output logic fire,
    output pdm_pkg::pdm_mode_t mode,
    output logic pending
);
    pdm_pkg::pdm_timer_state_t s;
    pdm_pkg::pdm_timer_state_t next_s;

    always_comb begin
        next_s = s;
        next_s.fire = 1'b0;
        if (start) begin
            // a new write restarts the delay with the latest code
            next_s.cnt = `PDM_ENTRY_CYCLES - 4'd1; // [RL3]
            next_s.pending = 1'b1;
            next_s.mode = pdm_pkg::pdm_decode(code); // [RL17]
        end else if (s.pending) begin
            if (s.cnt == 4'd1) begin
                next_s.fire = 1'b1; // [RL3]
                next_s.pending = 1'b0;
            end else begin
                next_s.cnt = s.cnt - 4'd1;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '{cnt: 4'd0, pending: 1'b0, fire: 1'b0, mode: pdm_pkg::MODE_NONE};
        end else begin
            s <= next_s;
        end
    end

    assign fire = s.fire;
    assign mode = s.mode;
    assign pending = s.pending;
endmodule : pdm_entry_timer

//--- hdl/pdm_power_down.sv
`timescale 1ns/1ps
`include "pdm_map.svh"
// What this block does
// [RL1] The mode and its wake method come from the six-bit power_down_select field, bits 15:10 of cpu_control_status.
// [RL2] Software writes all six select bits at once and keeps the top bit of the field at zero.
// [RL3] The chosen mode takes effect within nine clock cycles of the write to the select field.
// [RL4] Software pads the select write with no-operation instructions to cover that delay.
// [RL5] Code 000000 is no power-down, 001001 is light sleep woken by an enabled interrupt, 010001 by any interrupt.
// [RL6] Light sleep stops the CPU clock at its boundary but keeps interrupt logic and DMA running.
// [RL7] A wake by a non-enabled interrupt resumes at the entry point with no service routine.
// [RL8] A wake by an enabled interrupt runs the service routine and then resumes at the entry point.
// [RL9] The routine runs only with both global_irq_enable and nonmaskable_irq_enable set, else execution just resumes.
// [RL10] Code 011010 halts the PLL output clock so the chip stops, keeping state and freezing outputs.
// [RL11] Code 011100 stops the PLL input clock, keeping state, and needs a PLL re-lock after reset.
// [RL12] Both deep modes end only with device reset; interrupts do not wake them.
// [RL13] Functional outputs hold their last state in either deep mode.
// [RL14] Only external_clock_in and osc_divided_clock_out are gated; other input clocks are not.
// [RL15] With pll_engage at 0 the chip runs from external_clock_in and deep modes have no effect.
// [RL16] Software sets pll_engage before writing either deep-mode bit.
// [RL17] Any other select code is treated as no power-down with all clocks running.
module pdm_power_down (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [15:0] irq_request,
    output logic cpu_clock_enable,
    output logic dma_clock_enable,
    output logic pll_output_enable,
    output logic pll_input_enable,
    output logic external_clock_in_enable,
    output logic osc_divided_clock_out_enable,
    output logic io_freeze,
    output logic isr_take,
    output logic resume_at_entry
);
    pdm_bus_if bus ();

    pdm_pkg::pdm_top_state_t s;
    pdm_pkg::pdm_top_state_t next_s;
    logic select_write;
    logic timer_fire;
    pdm_pkg::pdm_mode_t timer_mode;
    logic timer_pending;
    logic enabled_hit;
    logic any_hit;
    logic in_deep;

    pdm_ahb_slave u_ahb (
        .clock(clock),
        .rst(rst),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .bus(bus.slave)
    );

    assign in_deep = (s.state == pdm_pkg::ST_DEEP_OUT) | (s.state == pdm_pkg::ST_DEEP_IN);
    // a halted cpu cannot write, and deep modes are left only through reset
    assign select_write = bus.wr_en & (bus.addr == `PDM_CPU_CTRL_OFFSET) & (s.state == pdm_pkg::ST_RUN); // [RL12]

    pdm_entry_timer u_timer (
        .clock(clock),
        .rst(rst),
        .start(select_write),
        .code(bus.wr_data[`PDM_SEL_MSB:`PDM_SEL_LSB]), // [RL1]
        .fire(timer_fire),
        .mode(timer_mode),
        .pending(timer_pending)
    );

    assign enabled_hit = |(irq_request & s.irq_enable);
    assign any_hit = |irq_request;

    function automatic logic [31:0] read_mux(input logic [7:0] addr, input pdm_pkg::pdm_top_state_t r,
                                              input logic pend);
        logic [31:0] d;
        d = 32'h0000_0000;
        case (addr)
            `PDM_CPU_CTRL_OFFSET: begin
                d[`PDM_SEL_MSB:`PDM_SEL_LSB] = r.power_down_select;
                d[`PDM_GLOBAL_IRQ_BIT] = r.global_irq_enable;
            end
            `PDM_PLL_OFFSET: d[`PDM_ENGAGE_BIT] = r.pll_engage;
            `PDM_IRQ_EN_OFFSET: d[15:0] = r.irq_enable;
            `PDM_STAT_OFFSET: begin
                d[1:0] = r.state;
                d[6:4] = r.mode;
                d[8] = pend;
                d[9] = r.cpu_clock_enable;
                d[10] = r.pll_output_enable;
                d[11] = r.pll_input_enable;
                d[12] = r.io_freeze;
                d[13] = r.deep_ignored;
            end
            default: d = 32'h0000_0000;
        endcase
        return d;
    endfunction : read_mux

    assign bus.rd_data = read_mux(bus.addr, s, timer_pending);

    always_comb begin
        next_s = s;
        next_s.isr_take = 1'b0;
        next_s.resume_at_entry = 1'b0;

        if (bus.wr_en & ~in_deep) begin
            case (bus.addr)
                `PDM_CPU_CTRL_OFFSET: begin
                    // the whole field is taken from one write, reserved bit included
                    next_s.power_down_select = bus.wr_data[`PDM_SEL_MSB:`PDM_SEL_LSB]; // [RL2]
                    next_s.global_irq_enable = bus.wr_data[`PDM_GLOBAL_IRQ_BIT];
                end
                `PDM_PLL_OFFSET: next_s.pll_engage = bus.wr_data[`PDM_ENGAGE_BIT];
                `PDM_IRQ_EN_OFFSET: next_s.irq_enable = bus.wr_data[15:0];
                default: next_s.irq_enable = s.irq_enable;
            endcase
        end

        unique case (s.state)
            pdm_pkg::ST_RUN: begin
                if (timer_fire) begin
                    next_s.mode = timer_mode; // [RL5]
                    unique case (timer_mode)
                        pdm_pkg::MODE_LIGHT_EN, pdm_pkg::MODE_LIGHT_ANY: begin
                            // interrupt logic and dma keep their clocks
                            next_s.state = pdm_pkg::ST_LIGHT;
                            next_s.cpu_clock_enable = 1'b0; // [RL6]
                        end
                        pdm_pkg::MODE_PLL_OUT: begin
                            if (s.pll_engage) begin // [RL15] [RL16]
                                next_s.state = pdm_pkg::ST_DEEP_OUT;
                                next_s.pll_output_enable = 1'b0; // [RL10]
                                next_s.cpu_clock_enable = 1'b0;
                                next_s.dma_clock_enable = 1'b0;
                                next_s.io_freeze = 1'b1; // [RL13]
                            end else begin
                                next_s.deep_ignored = 1'b1; // [RL15]
                            end
                        end
                        pdm_pkg::MODE_PLL_IN: begin
                            if (s.pll_engage) begin // [RL15] [RL16]
                                next_s.state = pdm_pkg::ST_DEEP_IN;
                                next_s.pll_input_enable = 1'b0; // [RL11]
                                next_s.pll_output_enable = 1'b0;
                                // only these two pin clocks are gated here
                                next_s.ext_clk_enable = 1'b0; // [RL14]
                                next_s.osc_out_enable = 1'b0; // [RL14]
                                next_s.cpu_clock_enable = 1'b0;
                                next_s.dma_clock_enable = 1'b0;
                                next_s.io_freeze = 1'b1; // [RL13]
                            end else begin
                                next_s.deep_ignored = 1'b1; // [RL15]
                            end
                        end
                        pdm_pkg::MODE_NONE: next_s.mode = pdm_pkg::MODE_NONE; // [RL17]
                    endcase
                end
            end
            pdm_pkg::ST_LIGHT: begin
                // enabled-only mode ignores sources that are not enabled
                if (enabled_hit | (any_hit & (s.mode == pdm_pkg::MODE_LIGHT_ANY))) begin // [RL5]
                    next_s.state = pdm_pkg::ST_RUN;
                    next_s.mode = pdm_pkg::MODE_NONE;
                    next_s.cpu_clock_enable = 1'b1;
                    if (enabled_hit & s.global_irq_enable & s.irq_enable[`PDM_NMI_EN_BIT]) begin
                        next_s.isr_take = 1'b1; // [RL8] [RL9]
                    end else begin
                        next_s.resume_at_entry = 1'b1; // [RL7] [RL9]
                    end
                end
            end
            pdm_pkg::ST_DEEP_OUT, pdm_pkg::ST_DEEP_IN: begin
                // no interrupt path out; only rst reloads the state
                next_s.state = s.state; // [RL12]
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            s <= '{
                state: pdm_pkg::ST_RUN,
                mode: pdm_pkg::MODE_NONE,
                power_down_select: `PDM_SEL_RESET,
                global_irq_enable: `PDM_GLOBAL_IRQ_RESET,
                pll_engage: `PDM_ENGAGE_RESET,
                irq_enable: `PDM_IRQ_EN_RESET,
                // reset is the only way out of a deep mode, so every clock comes back here
                cpu_clock_enable: 1'b1,
                dma_clock_enable: 1'b1,
                pll_output_enable: 1'b1,
                pll_input_enable: 1'b1,
                ext_clk_enable: 1'b1,
                osc_out_enable: 1'b1,
                io_freeze: 1'b0,
                isr_take: 1'b0,
                resume_at_entry: 1'b0,
                deep_ignored: 1'b0
            };
        end else begin
            s <= next_s;
        end
    end

    assign cpu_clock_enable = s.cpu_clock_enable;
    assign dma_clock_enable = s.dma_clock_enable;
    assign pll_output_enable = s.pll_output_enable;
    assign pll_input_enable = s.pll_input_enable;
    assign external_clock_in_enable = s.ext_clk_enable;
    assign osc_divided_clock_out_enable = s.osc_out_enable;
    assign io_freeze = s.io_freeze;
    assign isr_take = s.isr_take;
    assign resume_at_entry = s.resume_at_entry;
endmodule : pdm_power_down

//--- test/pdm_power_down_asserts.sv
`timescale 1ns/1ps
module pdm_power_down_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [15:0] irq_request,
    input wire logic cpu_clock_enable,
    input wire logic dma_clock_enable,
    input wire logic pll_output_enable,
    input wire logic pll_input_enable,
    input wire logic external_clock_in_enable,
    input wire logic osc_divided_clock_out_enable,
    input wire logic io_freeze,
    input wire logic isr_take,
    input wire logic resume_at_entry
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    sequence rd_taken_s;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence light_write_s;
        hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00 ##1 hwdata[15:10] == 6'h09 && cpu_clock_enable;
    endsequence
    sequence light_entry_s;
        ##9 cpu_clock_enable ##1 (!cpu_clock_enable && dma_clock_enable);
    endsequence
    read_wait_a: assert property (rd_taken_s |=> !hreadyout ##1 hreadyout)
        else $error("read data phase not one wait");
    write_nowait_a: assert property (hsel && htrans[1] && hready && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    light_entry_a: assert property (light_write_s |-> light_entry_s)
        else $error("light sleep entry timing wrong");
    deep_holds_a: assert property (io_freeze |=> io_freeze)
        else $error("deep mode left without reset");
    deep_stops_a: assert property (
        io_freeze |-> !cpu_clock_enable && !dma_clock_enable && !pll_output_enable)
        else $error("clocks running while frozen");
    pin_clocks_a: assert property (
        external_clock_in_enable == pll_input_enable && osc_divided_clock_out_enable == pll_input_enable)
        else $error("pin clock gate mismatch");
    wake_pulse_a: assert property ($rose(cpu_clock_enable) |-> isr_take != resume_at_entry)
        else $error("wake without exactly one pulse");
    wake_cause_a: assert property (
        isr_take || resume_at_entry |-> $past(irq_request) != 16'h0000 && !$past(cpu_clock_enable))
        else $error("wake pulse without interrupt");
    pulse_once_a: assert property (isr_take |=> !isr_take)
        else $error("service pulse too long");
endmodule : pdm_power_down_asserts
bind pdm_power_down pdm_power_down_asserts u_asserts (.*);

//--- test/pdm_irq_source.sv
`timescale 1ns/1ps
module pdm_irq_source (
    input wire logic clock,
    input wire logic rst,
    input wire logic go,
    input wire logic [15:0] mask,
    output logic [15:0] irq_request
);
    logic [1:0] hold;
    logic [15:0] held;
    // a request stands two cycles, then the lines drop back to idle
    always_ff @(posedge clock) begin
        if (rst) begin
            hold <= 2'd0;
        end else if (go) begin
            hold <= 2'd2;
        end else if (hold != 2'd0) begin
            hold <= hold - 2'd1;
        end
        if (go) begin
            held <= mask;
        end
    end
    assign irq_request = (hold != 2'd0) ? held : 16'h0000;
endmodule : pdm_irq_source

//--- test/pdm_power_down_bench.sv
`timescale 1ns/1ps
module pdm_power_down_bench;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h00000000;
    logic hreadyout, hresp, cpu_clock_enable, dma_clock_enable, pll_output_enable, pll_input_enable;
    logic external_clock_in_enable, osc_divided_clock_out_enable, io_freeze, isr_take, resume_at_entry;
    logic [31:0] hrdata, rd;
    logic [15:0] irq_request;
    logic [15:0] irq_mask = 16'h0000;
    logic irq_go = 1'b0;
    logic [31:0] rsv [3] = '{32'h0000a400, 32'h00006c00, 32'h00000400};
    logic [31:0] deep [2] = '{32'h00006800, 32'h00007000};
    logic [6:0] dexp [2] = '{7'h0f, 7'h01};
    int errors = 0;
    int n_tests = 0;
    always #5 clock = ~clock;
    pdm_power_down dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .irq_request(irq_request), .cpu_clock_enable(cpu_clock_enable),
        .dma_clock_enable(dma_clock_enable), .pll_output_enable(pll_output_enable),
        .pll_input_enable(pll_input_enable), .external_clock_in_enable(external_clock_in_enable),
        .osc_divided_clock_out_enable(osc_divided_clock_out_enable), .io_freeze(io_freeze),
        .isr_take(isr_take), .resume_at_entry(resume_at_entry));
    pdm_irq_source irq_src (.clock(clock), .rst(rst), .go(irq_go), .mask(irq_mask), .irq_request(irq_request));
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wr ? d : 32'h00000000;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : bus
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h00000000);
        chk(name, e, rd & m);
    endtask : rdchk
    task automatic outs(input string name, input logic [6:0] e);
        chk(name, {25'h0, e}, {25'h0, cpu_clock_enable, dma_clock_enable, pll_output_enable,
            pll_input_enable, external_clock_in_enable, osc_divided_clock_out_enable, io_freeze});
    endtask : outs
    task automatic sleep(input logic [31:0] d);
        bus(1'b1, 8'h00, d);
        repeat (9) @(posedge clock);
        chk("cpu_clock_early", 32'h1, {31'h0, cpu_clock_enable});
        @(posedge clock);
        chk("cpu_clock_off", 32'h0, {31'h0, cpu_clock_enable});
    endtask : sleep
    // expected {cpu clock back, service taken, direct resume}
    task automatic wake(input logic [15:0] m, input logic [2:0] e);
        int i;
        irq_mask <= m;
        irq_go <= 1'b1;
        @(posedge clock);
        irq_go <= 1'b0;
        for (i = 0; i < 8 && cpu_clock_enable !== 1'b1; i++) @(posedge clock);
        chk("wake", {29'h0, e}, {29'h0, cpu_clock_enable, isr_take, resume_at_entry});
    endtask : wake
    task automatic do_reset();
        rst <= 1'b1;
        repeat (3) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
    endtask : do_reset
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        outs("reset_outs", 7'h7e);
        rdchk("select_reset", 8'h00, 32'hffffffff, 32'h00000000);
        rdchk("pll_reset", 8'h04, 32'hffffffff, 32'h00000000);
        rdchk("status_reset", 8'h0c, 32'h00003f73, 32'h00000e00);
        bus(1'b1, 8'h10, 32'hffffffff);
        rdchk("unmapped", 8'h10, 32'hffffffff, 32'h00000000);
        bus(1'b1, 8'h08, 32'h00000003);
        sleep(32'h00002401);
        outs("light", 7'h3e);
        rdchk("status_light", 8'h0c, 32'h00003f73, 32'h00000c11);
        wake(16'h0001, 3'b110);
        rdchk("select_kept", 8'h00, 32'h0000fc01, 32'h00002401);
        sleep(32'h00002400);
        wake(16'h0020, 3'b000);
        wake(16'h0001, 3'b101);
        sleep(32'h00004401);
        wake(16'h0020, 3'b101);
        bus(1'b1, 8'h08, 32'h00000001);
        sleep(32'h00002401);
        wake(16'h0001, 3'b101);
        foreach (rsv[i]) begin
            bus(1'b1, 8'h00, rsv[i]);
            repeat (12) @(posedge clock);
            outs("reserved", 7'h7e);
        end
        bus(1'b1, 8'h00, 32'h00006800);
        repeat (12) @(posedge clock);
        outs("bypass", 7'h7e);
        rdchk("ignored_flag", 8'h0c, 32'h00002000, 32'h00002000);
        foreach (deep[i]) begin
            bus(1'b1, 8'h04, 32'h00000001);
            bus(1'b1, 8'h00, deep[i]);
            repeat (12) @(posedge clock);
            outs("deep", dexp[i]);
            wake(16'hffff, 3'b000);
            bus(1'b1, 8'h00, 32'h00000000);
            repeat (12) @(posedge clock);
            outs("deep_held", dexp[i]);
            do_reset();
            outs("after_reset", 7'h7e);
        end
        tally_and_finish();
    end
endmodule : pdm_power_down_bench
